// ---- hdl/spc_pkg.sv ----
package spc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets, one aligned word each)
    localparam logic [7:0] SPC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SPC_OFF_ZPTR = 8'h04;
    localparam logic [7:0] SPC_OFF_DATA = 8'h08;
    localparam logic [7:0] SPC_OFF_INSN = 8'h0c;
    localparam logic [7:0] SPC_OFF_LOAD = 8'h10;
    localparam logic [7:0] SPC_OFF_STAT = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int SPC_CMD_W = 5;
    localparam int SPC_BIT_EN = 0;
    localparam int SPC_BIT_ERS = 1;
    localparam int SPC_BIT_WRT = 2;
    localparam int SPC_BIT_RFL = 3;
    localparam int SPC_BIT_CTP = 4;
    localparam logic [4:0] SPC_CTRL_RESET = 5'h00;
    localparam logic [4:0] SPC_PAT_CLEAR = 5'h11;
    localparam logic [4:0] SPC_PAT_FUSE = 5'h09;
    localparam logic [4:0] SPC_PAT_WRITE = 5'h05;
    localparam logic [4:0] SPC_PAT_ERASE = 5'h03;
    localparam logic [4:0] SPC_PAT_FILL = 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction issue and status fields
    localparam int SPC_INSN_STORE = 0;
    localparam int SPC_INSN_LOAD = 1;
    localparam int SPC_STAT_BUSY = 0;
    localparam int SPC_STAT_ARMED = 1;
    localparam int SPC_STAT_LOAD_OPEN = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes and windows
    localparam int SPC_STORE_WINDOW = 4;
    localparam int SPC_LOAD_WINDOW = 3;
    localparam int SPC_Z_W = 16;
    localparam int SPC_WORD_W = 16;
    localparam int SPC_BUF_DEPTH = 32;
    localparam logic [15:0] SPC_ERASED_WORD = 16'hffff;
    localparam logic [2:0] SPC_HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {SPC_IDLE, SPC_ARMED, SPC_PAGE_BUSY} spc_state_e;

endpackage : spc_pkg

// ---- hdl/spc_buf_if.sv ----
`timescale 1ns/1ps
interface spc_buf_if #(parameter int W = 16, parameter int AW = 5);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0] wr_data;
    logic clear;
    logic [AW-1:0] rd_addr;
    logic [W-1:0] rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, clear, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, clear, rd_addr, output rd_data);
endinterface : spc_buf_if

// ---- hdl/spc_win_timer.sv ----
`timescale 1ns/1ps
module spc_win_timer #(
    parameter int CYCLES = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic cancel,
    output logic open,
    output logic expire
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] START = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] count_q;

    initial
    begin
        if (CYCLES < 1)
            $error("spc_win_timer: CYCLES must be at least one");
    end

    // Window is open in each of the CYCLES cycles after the load edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_q <= '0;
        else if (load)
            count_q <= START;
        else if (cancel)
            count_q <= '0;
        else if (count_q != '0)
            count_q <= count_q - ONE;
    end

    assign open = (count_q != '0);
    assign expire = (count_q == ONE) && !load && !cancel;

endmodule : spc_win_timer

// ---- hdl/spc_page_buf.sv ----
`timescale 1ns/1ps
module spc_page_buf
    import spc_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    spc_buf_if.mem bus
);

    logic [W-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] valid_q;
    logic [W-1:0] rd_data_q;

    // Array itself has no reset; the valid bits make a clear a single-cycle act
    always_ff @(posedge hclk)
    begin
        if (bus.wr_en)
            mem_q[bus.wr_addr] <= bus.wr_data;
    end

    // A fill in the cycle of a clear survives it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            valid_q <= '0;
        else
        begin
            if (bus.clear)
                valid_q <= '0;
            if (bus.wr_en)
                valid_q[bus.wr_addr] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_data_q <= SPC_ERASED_WORD[W-1:0];
        else if (valid_q[bus.rd_addr])
            rd_data_q <= mem_q[bus.rd_addr];
        else
            rd_data_q <= SPC_ERASED_WORD[W-1:0];
    end

    assign bus.rd_data = rd_data_q;

endmodule : spc_page_buf

// ---- hdl/spc_ctrl.sv ----
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Contract
// - Enable bit opens store instruction for only the next four cycles.
// - Enable with a command bit makes the next store do that command.
// - Enable alone makes the next store write data pair into buffer.
// - Buffer fill ignores pointer bit zero; buffer addressing is word aligned.
// - Enable clears after store completes, or after four idle cycles.
// - During page erase or write, enable stays one until done.
// - Only patterns 10001, 01001, 00101, 00011, 00001 take effect.
// - Page write programs buffer to upper pointer page; processor halted.
// - Page erase erases upper pointer page; clears only on completion.
// - Load within three cycles of fuse read returns lock or fuse bits.
// - Writing buffer clear command while filling discards all buffer content.
module spc_ctrl
    import spc_pkg::*;
#(
    parameter int BUF_DEPTH = SPC_BUF_DEPTH,
    parameter int Z_W = SPC_Z_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic flash_req,
    output logic flash_erase,
    output logic flash_write,
    output logic [Z_W-$clog2(BUF_DEPTH)-2:0] flash_page,
    input wire logic flash_done,
    input wire logic [$clog2(BUF_DEPTH)-1:0] flash_rd_addr,
    output logic [SPC_WORD_W-1:0] flash_rd_data,
    input wire logic [7:0] fuse_bits,
    input wire logic [7:0] lock_bits,
    output logic cpu_halt
);
    localparam int AW = $clog2(BUF_DEPTH);
    localparam int PW = Z_W - AW - 1;

    initial
    begin
        if (BUF_DEPTH < 2 || (1 << AW) != BUF_DEPTH)
            $error("spc_ctrl: BUF_DEPTH must be a power of two, at least two");
        if (PW < 1 || Z_W > 32)
            $error("spc_ctrl: Z_W too small for BUF_DEPTH or above 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic pattern_ok(input logic [4:0] p);
        pattern_ok = (p == SPC_PAT_CLEAR) || (p == SPC_PAT_FUSE) ||
                     (p == SPC_PAT_WRITE) || (p == SPC_PAT_ERASE) ||
                     (p == SPC_PAT_FILL);
    endfunction : pattern_ok

    function automatic logic is_page_op(input logic [4:0] p);
        is_page_op = (p == SPC_PAT_WRITE) || (p == SPC_PAT_ERASE);
    endfunction : is_page_op

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    spc_state_e state_q;
    logic [4:0] ctrl_q;
    logic [Z_W-1:0] zptr_q;
    logic [SPC_WORD_W-1:0] data_q;
    logic [7:0] load_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_take;
    logic addr_take;
    logic wr_fire;
    logic ctrl_wr;
    logic store_fire;
    logic load_fire;
    logic store_open;
    logic store_expire;
    logic load_open;
    logic done_op;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    logic buf_wr_q;
    logic [AW-1:0] buf_addr_q;
    logic [SPC_WORD_W-1:0] buf_data_q;
    logic buf_clear_q;
    logic flash_req_q;
    logic flash_erase_q;
    logic flash_write_q;
    logic [PW-1:0] flash_page_q;
    logic cpu_halt_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    spc_buf_if #(.W(SPC_WORD_W), .AW(AW)) buf_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign addr_take = hsel && hready && htrans[1];
    assign rd_take = addr_take && !hwrite;
    assign wr_fire = wr_pend_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= addr_take && hwrite && (hsize == SPC_HSIZE_WORD) &&
                         (haddr[31:8] == 24'h000000);
            wr_addr_q <= haddr[7:0];
        end
    end

    assign stat_word = {29'h0, load_open, (state_q == SPC_ARMED),
                        (state_q == SPC_PAGE_BUSY)};

    always_comb
    begin
        rd_mux = 32'h00000000;
        if (haddr[31:8] == 24'h000000)
        begin
            case (haddr[7:0])
                SPC_OFF_CTRL: rd_mux = {27'h0, ctrl_q};
                SPC_OFF_ZPTR: rd_mux = 32'(zptr_q);
                SPC_OFF_DATA: rd_mux = 32'(data_q);
                SPC_OFF_LOAD: rd_mux = {24'h0, load_q};
                SPC_OFF_STAT: rd_mux = stat_word;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // Read data sampled in the address phase, so it stands for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (rd_take)
            hrdata_q <= rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            zptr_q <= '0;
            data_q <= '0;
        end
        else if (wr_fire)
        begin
            if (wr_addr_q == SPC_OFF_ZPTR)
                zptr_q <= hwdata[Z_W-1:0];
            if (wr_addr_q == SPC_OFF_DATA)
                data_q <= hwdata[SPC_WORD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    // Control is locked while a page operation runs
    assign ctrl_wr = wr_fire && (wr_addr_q == SPC_OFF_CTRL) &&
                     (state_q != SPC_PAGE_BUSY) && pattern_ok(hwdata[4:0]);
    assign store_fire = wr_fire && (wr_addr_q == SPC_OFF_INSN) &&
                        hwdata[SPC_INSN_STORE] && (state_q == SPC_ARMED) &&
                        store_open;
    assign load_fire = wr_fire && (wr_addr_q == SPC_OFF_INSN) && hwdata[SPC_INSN_LOAD];
    assign done_op = (state_q == SPC_PAGE_BUSY) && flash_done;

    spc_win_timer #(.CYCLES(SPC_STORE_WINDOW)) u_store_win (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(ctrl_wr),
        .cancel(store_fire),
        .open(store_open),
        .expire(store_expire)
    );

    spc_win_timer #(.CYCLES(SPC_LOAD_WINDOW)) u_load_win (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(ctrl_wr && (hwdata[4:0] == SPC_PAT_FUSE)),
        .cancel(load_fire || store_fire),
        .open(load_open),
        .expire()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= SPC_IDLE;
            ctrl_q <= SPC_CTRL_RESET;
        end
        else
        begin
            case (state_q)
                SPC_IDLE, SPC_ARMED:
                begin
                    if (ctrl_wr)
                    begin
                        state_q <= SPC_ARMED;
                        ctrl_q <= hwdata[4:0];
                    end
                    else if (store_fire && is_page_op(ctrl_q))
                        state_q <= SPC_PAGE_BUSY;
                    else if (store_fire || store_expire)
                    begin
                        state_q <= SPC_IDLE;
                        ctrl_q <= SPC_CTRL_RESET;
                    end
                    else if (load_fire && load_open && ctrl_q == SPC_PAT_FUSE)
                    begin
                        state_q <= SPC_IDLE;
                        ctrl_q <= SPC_CTRL_RESET;
                    end
                end
                SPC_PAGE_BUSY:
                begin
                    if (done_op)
                    begin
                        state_q <= SPC_IDLE;
                        ctrl_q <= SPC_CTRL_RESET;
                    end
                end
                default:
                begin
                    state_q <= SPC_IDLE;
                    ctrl_q <= SPC_CTRL_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page buffer fill and clear

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            buf_wr_q <= 1'b0;
            buf_addr_q <= '0;
            buf_data_q <= '0;
            buf_clear_q <= 1'b0;
        end
        else
        begin
            buf_wr_q <= store_fire && (ctrl_q == SPC_PAT_FILL);
            buf_addr_q <= zptr_q[AW:1];
            buf_data_q <= data_q;
            // Cleared both when the command is written and when it is executed
            buf_clear_q <= (ctrl_wr && hwdata[4:0] == SPC_PAT_CLEAR) ||
                           (store_fire && ctrl_q == SPC_PAT_CLEAR);
        end
    end

    assign buf_bus.wr_en = buf_wr_q;
    assign buf_bus.wr_addr = buf_addr_q;
    assign buf_bus.wr_data = buf_data_q;
    assign buf_bus.clear = buf_clear_q;
    assign buf_bus.rd_addr = flash_rd_addr;

    spc_page_buf #(.W(SPC_WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(buf_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Flash array request and processor halt

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flash_req_q <= 1'b0;
            flash_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
            flash_page_q <= '0;
            cpu_halt_q <= 1'b0;
        end
        else
        begin
            flash_req_q <= store_fire && is_page_op(ctrl_q);
            if (store_fire && is_page_op(ctrl_q))
            begin
                flash_erase_q <= (ctrl_q == SPC_PAT_ERASE);
                flash_write_q <= (ctrl_q == SPC_PAT_WRITE);
                flash_page_q <= zptr_q[Z_W-1:AW+1];
                cpu_halt_q <= 1'b1;
            end
            else if (done_op)
            begin
                flash_erase_q <= 1'b0;
                flash_write_q <= 1'b0;
                cpu_halt_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load result: fuse or lock bits inside the window, else zero

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            load_q <= 8'h00;
        else if (load_fire)
        begin
            if (load_open && state_q == SPC_ARMED && ctrl_q == SPC_PAT_FUSE)
                load_q <= zptr_q[0] ? fuse_bits : lock_bits;
            else
                load_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign flash_req = flash_req_q;
    assign flash_erase = flash_erase_q;
    assign flash_write = flash_write_q;
    assign flash_page = flash_page_q;
    assign flash_rd_data = buf_bus.rd_data;
    assign cpu_halt = cpu_halt_q;

endmodule : spc_ctrl

// ---- tb/spc_ctrl_properties.sv ----
`timescale 1ns/1ps
module spc_ctrl_properties
    import spc_pkg::*;
#(
    parameter int BUF_DEPTH = 32,
    parameter int Z_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hwdata,
    input wire logic flash_req,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [Z_W-$clog2(BUF_DEPTH)-2:0] flash_page,
    input wire logic flash_done,
    input wire logic cpu_halt
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Page operation handshake
    req_pulse_a: assert property (flash_req |=> !flash_req)
        else $error("page request longer than one cycle");
    req_kind_a: assert property (flash_req |-> (flash_erase ^ flash_write))
        else $error("page request without exactly one operation kind");
    op_excl_a: assert property (!(flash_erase && flash_write))
        else $error("erase and write active together");
    halt_match_a: assert property (cpu_halt == (flash_erase || flash_write))
        else $error("processor halt does not follow page operation");
    // Busy must not drop early, or the array sees a half-done page
    op_hold_a: assert property ((flash_erase || flash_write) && !flash_done
        |=> $stable({flash_erase, flash_write}))
        else $error("page operation ended without completion");
    op_end_a: assert property ((flash_erase || flash_write) && flash_done
        |=> !cpu_halt && !flash_erase && !flash_write)
        else $error("page operation outlived completion");
    page_hold_a: assert property ((flash_erase || flash_write) && !flash_req
        |-> $stable(flash_page))
        else $error("page address moved during operation");
    req_cause_a: assert property ($rose(flash_req) |-> $past(hwdata[SPC_INSN_STORE]))
        else $error("page request without a store issue");
endmodule : spc_ctrl_properties

// ---- tb/spc_flash_model.sv ----
`timescale 1ns/1ps
module spc_flash_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic flash_req,
    output logic flash_done,
    output logic [4:0] flash_rd_addr = 5'h00,
    input wire logic [15:0] flash_rd_data
);
    int lat = 1;
    int cnt;

    // Completion only after the chosen latency; slow answers hold the page op open
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 0;
            flash_done <= 1'b0;
        end
        else
        begin
            flash_done <= (cnt == 1);
            if (flash_req)
                cnt <= lat;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end

    // Array-side read of the page buffer, data one edge after the address
    task automatic peek(input logic [4:0] a, output logic [15:0] d);
        flash_rd_addr <= a;
        repeat (2) @(posedge hclk);
        d = flash_rd_data;
    endtask : peek
endmodule : spc_flash_model

// ---- tb/tb_spc_ctrl.sv ----
`timescale 1ns/1ps
module tb_spc_ctrl;
    import spc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_req, flash_erase, flash_write;
    logic flash_done, cpu_halt;
    logic [31:0] haddr, hwdata, hrdata, rv, z, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] flash_page;
    logic [4:0] flash_rd_addr, op;
    logic [15:0] flash_rd_data, bw;
    logic [15:0] sh [32];
    logic [7:0] fuse_bits, lock_bits;
    int n_errors, tests_run;

    spc_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
        .hwdata, .hreadyout, .hresp, .hrdata, .flash_req, .flash_erase, .flash_write,
        .flash_page, .flash_done, .flash_rd_addr, .flash_rd_data, .fuse_bits, .lock_bits,
        .cpu_halt);
    spc_flash_model fm (.hclk, .hresetn, .flash_req, .flash_done, .flash_rd_addr,
        .flash_rd_data);

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // Bounded wait for hready; a hung slave ends the run
    task automatic tick();
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            k++;
            if (k > 64)
            begin
                n_errors++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask : tick

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        tick();
        htrans <= 2'h0;
        hwdata <= wd;
        tick();
        rv = hrdata;
    endtask : bus

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(what, rv, e);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : rdchk

    // Arm with a pattern, then issue the store after a gap of idle cycles
    task automatic store(input logic [4:0] p, input int gap);
        bus(1'b1, SPC_OFF_CTRL, {27'h0, p});
        idle(gap);
        bus(1'b1, SPC_OFF_INSN, 32'h1);
    endtask : store

    task automatic bufchk(input logic [4:0] a);
        fm.peek(a, bw);
        chk("buffer word", {16'h0, bw}, {16'h0, sh[a]});
    endtask : bufchk

    task automatic fill(input int gap);
        z = $urandom();
        d = $urandom();
        bus(1'b1, SPC_OFF_ZPTR, z);
        bus(1'b1, SPC_OFF_DATA, d);
        store(SPC_PAT_FILL, gap);
    endtask : fill

    function automatic logic [31:0] ok_pat(input logic [4:0] p);
        return (p inside {SPC_PAT_CLEAR, SPC_PAT_FUSE, SPC_PAT_WRITE, SPC_PAT_ERASE,
            SPC_PAT_FILL}) ? {27'h0, p} : 32'h0;
    endfunction : ok_pat

    function automatic logic [31:0] exp_load(input int j, input logic z0);
        return (j == 2) ? 32'h0 : {24'h0, z0 ? fuse_bits : lock_bits};
    endfunction : exp_load

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SPC_HSIZE_WORD;
        hwdata = 32'h0;
        fuse_bits = 8'h00;
        lock_bits = 8'h00;
        n_errors = 0;
        tests_run = 0;
        foreach (sh[i]) sh[i] = SPC_ERASED_WORD;
        void'($urandom(32'hac73));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("ctrl", SPC_OFF_CTRL, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        $display("Test reset done");
        repeat (8)
        begin
            fill(0);
            sh[z[5:1]] = d[15:0];
            rdchk("ctrl", SPC_OFF_CTRL, 32'h0);
            bufchk(z[5:1]);
        end
        $display("Test fill done");
        // Gap 2 lands on the last open cycle, gap 3 one past it
        for (int g = 2; g < 4; g++)
        begin
            fill(g);
            if (g == 2)
                sh[z[5:1]] = d[15:0];
            rdchk("ctrl", SPC_OFF_CTRL, 32'h0);
            bufchk(z[5:1]);
        end
        $display("Test window done");
        hsize <= 3'h0;
        bus(1'b1, SPC_OFF_CTRL, 32'h1);
        hsize <= SPC_HSIZE_WORD;
        rdchk("ctrl byte", SPC_OFF_CTRL, 32'h0);
        for (int p = 0; p < 32; p++)
        begin
            op = p[4:0];
            bus(1'b1, SPC_OFF_CTRL, ($urandom() & 32'hffffffe0) | {27'h0, op});
            rdchk("ctrl", SPC_OFF_CTRL, ok_pat(op));
            idle(5);
            if (op == SPC_PAT_CLEAR)
                foreach (sh[i]) sh[i] = SPC_ERASED_WORD;
        end
        $display("Test patterns done");
        for (int i = 0; i < 4; i++)
        begin
            op = i[1] ? SPC_PAT_WRITE : SPC_PAT_ERASE;
            fm.lat = i[0] ? 20 : 1;
            z = $urandom();
            bus(1'b1, SPC_OFF_ZPTR, z);
            store(op, 0);
            if (i[0])
            begin
                rdchk("ctrl busy", SPC_OFF_CTRL, {27'h0, op});
                chk("page", {22'h0, flash_page}, {22'h0, z[15:6]});
                chk("halt", {31'h0, cpu_halt}, 32'h1);
                chk("kind", {30'h0, flash_write, flash_erase},
                    (op == SPC_PAT_WRITE) ? 32'h2 : 32'h1);
                rdchk("stat busy", SPC_OFF_STAT, 32'h1);
            end
            idle(2);
            for (int k = 0; cpu_halt !== 1'b0; k++)
            begin
                if (k > 100)
                begin
                    n_errors++;
                    report_and_stop();
                end
                idle(1);
            end
            rdchk("ctrl done", SPC_OFF_CTRL, 32'h0);
        end
        $display("Test page ops done");
        // Gap 1 is the last open load cycle, gap 2 is late
        for (int j = 0; j < 3; j++)
        begin
            fuse_bits <= 8'($urandom());
            lock_bits <= 8'($urandom());
            z = {$urandom()} & 32'hfffffffe | j[0];
            bus(1'b1, SPC_OFF_ZPTR, z);
            bus(1'b1, SPC_OFF_CTRL, {27'h0, SPC_PAT_FUSE});
            idle(j);
            bus(1'b1, SPC_OFF_INSN, 32'h2);
            rdchk("load", SPC_OFF_LOAD, exp_load(j, z[0]));
            idle(5);
        end
        $display("Test fuse read done");
        fill(0);
        store(SPC_PAT_CLEAR, 0);
        foreach (sh[i]) sh[i] = SPC_ERASED_WORD;
        for (int a = 0; a < 32; a++)
            bufchk(a[4:0]);
        $display("Test buffer clear done");
        report_and_stop();
    end
endmodule : tb_spc_ctrl

bind spc_ctrl spc_ctrl_properties #(.BUF_DEPTH(BUF_DEPTH), .Z_W(Z_W)) u_props (.hclk, .hresetn,
    .hwdata, .flash_req, .flash_erase, .flash_write, .flash_page, .flash_done, .cpu_halt);
